/* hdl/mio_params.svh */
// Constants of the machine I/O command and status block: timing, offsets, fields, resets.
// Assumes a 125 MHz core clock and a byte-framed serial link, one start and one stop bit.
`ifndef MIO_PARAMS_SVH
`define MIO_PARAMS_SVH

// Link timing
`define MIO_CLK_MHZ        125
`define MIO_BAUD           9600
`define MIO_BIT_TIME_NS    104167
`define MIO_BIT_CYCLES     ((`MIO_BIT_TIME_NS * `MIO_CLK_MHZ) / 1000)

// Register offsets on the local port
`define MIO_OFS_COMMAND    4'h0
`define MIO_OFS_STATUS     4'h1
`define MIO_OFS_IRQ_STAT   4'h2
`define MIO_OFS_IRQ_MASK   4'h3
`define MIO_OFS_CTRL       4'h4
`define MIO_OFS_LAST_SENT  4'h5

// Command word fields
`define MIO_CMD_LED        0
`define MIO_CMD_PASS       1
`define MIO_CMD_MIST       2
`define MIO_CMD_FLOOD      3
`define MIO_CMD_SPINDLE_N  4
`define MIO_CMD_INDEX_N    5
`define MIO_CMD_SPD_INC_N  6
`define MIO_CMD_SPD_DEC_N  7

// Status word fields, every one active low
`define MIO_ST_X_HOME      0
`define MIO_ST_Y_HOME      1
`define MIO_ST_Z_HOME      2
`define MIO_ST_INDEX_IN    3
`define MIO_ST_INDEX_OUT   4
`define MIO_ST_FAULT       5
`define MIO_ST_CONTACTOR   6
`define MIO_ST_CRASH       7

// Interrupt status and mask fields
`define MIO_IRQ_CMD_RX     0
`define MIO_IRQ_STAT_TX    1
`define MIO_IRQ_FRAME_ERR  2
`define MIO_IRQ_ESTOP      3

// Control fields
`define MIO_CTRL_LINK_EN   0
`define MIO_CTRL_REPLY_EN  1

// Reset values
`define MIO_CMD_RESET      8'hF0
`define MIO_CTRL_RESET     8'h03
`define MIO_MASK_RESET     8'h00
`define MIO_IRQ_RESET      8'h00

`endif

/* hdl/mio_pkg.sv */
// Types shared by the machine I/O command and status block.
// Assumes mio_params.svh carries every number; this package holds only types.
package mio_pkg;

    // Serial framing states, Gray coded along idle, start, data, stop
    typedef enum logic [1:0] {
        MIO_IDLE  = 2'b00,
        MIO_START = 2'b01,
        MIO_DATA  = 2'b11,
        MIO_STOP  = 2'b10
    } mio_frame_t;

endpackage : mio_pkg

/* hdl/mio_rx.sv */
// Serial byte receiver of the machine I/O block: start bit, eight data bits LSB first, stop.
// Assumes the link input is already synchronous to core_clk and idles high.
`include "mio_params.svh"

module mio_rx #(
    parameter int BIT_CYCLES = `MIO_BIT_CYCLES
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    // Link side
    input  wire logic       rx_line,
    input  wire logic       rx_enable,
    // Byte side
    output logic            byte_valid,
    output logic [7:0]      byte_data,
    output logic            frame_err
);

    localparam logic [15:0] FULL_LAST = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] HALF_LAST = 16'(BIT_CYCLES / 2 - 1);

    mio_pkg::mio_frame_t state_reg, state_next;
    logic [15:0]         cnt_reg,   cnt_next;
    logic [2:0]          bit_reg,   bit_next;
    logic [7:0]          shift_reg, shift_next;
    logic                valid_reg, valid_next;
    logic                ferr_reg,  ferr_next;

    // Bit timing and sampling at mid-bit
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg + 16'h0001;
        bit_next   = bit_reg;
        shift_next = shift_reg;
        valid_next = 1'b0;
        ferr_next  = 1'b0;
        case (state_reg)
            mio_pkg::MIO_IDLE: begin
                cnt_next = 16'h0000;
                if (rx_enable && !rx_line) begin
                    state_next = mio_pkg::MIO_START;
                end
            end
            mio_pkg::MIO_START: begin
                // A glitch shorter than half a bit is not a start
                if (cnt_reg == HALF_LAST) begin
                    cnt_next   = 16'h0000;
                    bit_next   = 3'h0;
                    state_next = rx_line ? mio_pkg::MIO_IDLE : mio_pkg::MIO_DATA;
                end
            end
            mio_pkg::MIO_DATA: begin
                if (cnt_reg == FULL_LAST) begin
                    cnt_next   = 16'h0000;
                    shift_next = {rx_line, shift_reg[7:1]};
                    bit_next   = bit_reg + 3'h1;
                    if (bit_reg == 3'h7) begin
                        state_next = mio_pkg::MIO_STOP;
                    end
                end
            end
            mio_pkg::MIO_STOP: begin
                if (cnt_reg == FULL_LAST) begin
                    cnt_next   = 16'h0000;
                    valid_next = rx_line;
                    ferr_next  = !rx_line;
                    state_next = mio_pkg::MIO_IDLE;
                end
            end
            default: begin
                state_next = mio_pkg::MIO_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= mio_pkg::MIO_IDLE;
            cnt_reg   <= 16'h0000;
            bit_reg   <= 3'h0;
            shift_reg <= 8'h00;
            valid_reg <= 1'b0;
            ferr_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            bit_reg   <= bit_next;
            shift_reg <= shift_next;
            valid_reg <= valid_next;
            ferr_reg  <= ferr_next;
        end
    end

    assign byte_valid = valid_reg;
    assign byte_data  = shift_reg;
    assign frame_err  = ferr_reg;

endmodule : mio_rx

/* hdl/mio_top.sv */
// Machine I/O command and status block: serial command in, status word out, drive outputs.
// Assumes all machine inputs and the link receive line are synchronous to core_clk.
// The differential line drivers and receivers sit outside; this block sees logic levels.
`include "mio_params.svh"

// How it works
// - Command and status travel over one serial byte link to the host.
// - Status is captured in an eight-bit latch, then that latch is transmitted.
// - Five status bits mirror home and index switches, low while closed.
// - Fault status bit reads low whenever a drive fault is present.
// - Contactor status bit reads low while start or reverse contactor is energized.
// - Crash status bit follows the system crash line, treated like emergency stop.
// - Emergency stop condition is reported to the host inside the status word.
// - One command bit lights the LED, one passes through to the drive controller.
// - Two command bits drive the mist and flood triac outputs.
// - Four low-active command bits drive the spindle contactor and three solenoids.
module mio_top #(
    parameter int BIT_CYCLES = `MIO_BIT_CYCLES
) (
    // Clock and power-unit reset
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    // Serial link to the host
    input  wire logic       link_rx,
    output logic            link_tx,
    // Machine status inputs
    input  wire logic       x_home_closed_n,
    input  wire logic       y_home_closed_n,
    input  wire logic       z_home_closed_n,
    input  wire logic       index_in_closed_n,
    input  wire logic       index_out_closed_n,
    input  wire logic       drive_fault,
    input  wire logic       spindle_start_on,
    input  wire logic       spindle_reverse_on,
    input  wire logic       system_crash_line_n,
    input  wire logic       estop_released,
    // Machine outputs
    output logic            status_led_on,
    output logic            drive_passthru,
    output logic            mist_triac_on,
    output logic            flood_triac_on,
    output logic            spindle_enable_n,
    output logic            index_solenoid_n,
    output logic            speed_inc_solenoid_n,
    output logic            speed_dec_solenoid_n,
    // Local register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    // Interrupt
    output logic            irq
);

    localparam logic [15:0] FULL_LAST = 16'(BIT_CYCLES - 1);

    // Receiver outputs
    logic       rx_valid;
    logic [7:0] rx_data;
    logic       rx_ferr;

    // Register state
    logic [7:0] cmd_reg,    cmd_next;
    logic [7:0] ctrl_reg,   ctrl_next;
    logic [7:0] mask_reg,   mask_next;
    logic [7:0] irqst_reg,  irqst_next;
    logic [7:0] rdata_reg,  rdata_next;
    logic       irq_reg,    irq_next;
    logic       crash_prev_reg, crash_prev_next;

    // Transmit state
    mio_pkg::mio_frame_t tx_state_reg, tx_state_next;
    logic [15:0] tx_cnt_reg,   tx_cnt_next;
    logic [2:0]  tx_bit_reg,   tx_bit_next;
    logic [7:0]  tx_shift_reg, tx_shift_next;
    logic [7:0]  latch_reg,    latch_next;
    logic        tx_line_reg,  tx_line_next;
    logic        pend_reg,     pend_next;
    logic        tx_done;

    // Live status word and events
    logic [7:0] status_word;
    logic       estop_event;
    logic       reply_req;

    // Receiver for command bytes
    mio_rx #(
        .BIT_CYCLES (BIT_CYCLES)
    ) u_rx (
        .core_clk   (core_clk),
        .arst_n     (arst_n),
        .rx_line    (link_rx),
        .rx_enable  (ctrl_reg[`MIO_CTRL_LINK_EN]),
        .byte_valid (rx_valid),
        .byte_data  (rx_data),
        .frame_err  (rx_ferr)
    );

    // Status word assembly; every bit is low-true so an open wire reads as idle
    always_comb begin
        status_word                     = 8'hFF;
        status_word[`MIO_ST_X_HOME]     = x_home_closed_n;
        status_word[`MIO_ST_Y_HOME]     = y_home_closed_n;
        status_word[`MIO_ST_Z_HOME]     = z_home_closed_n;
        status_word[`MIO_ST_INDEX_IN]   = index_in_closed_n;
        status_word[`MIO_ST_INDEX_OUT]  = index_out_closed_n;
        status_word[`MIO_ST_FAULT]      = !drive_fault;
        status_word[`MIO_ST_CONTACTOR]  = !(spindle_start_on || spindle_reverse_on);
        // Crash and emergency stop share one bit, both stop the machine
        status_word[`MIO_ST_CRASH]      = system_crash_line_n && estop_released;
    end

    // Falling edge of the crash bit raises the emergency stop event
    assign estop_event     = crash_prev_reg && !status_word[`MIO_ST_CRASH];
    assign crash_prev_next = status_word[`MIO_ST_CRASH];

    // A valid command byte asks for a reply when replies are enabled
    assign reply_req = rx_valid && ctrl_reg[`MIO_CTRL_REPLY_EN];

    // Transmitter: latch status at reply start, shift it out LSB first
    always_comb begin
        tx_state_next = tx_state_reg;
        tx_cnt_next   = tx_cnt_reg + 16'h0001;
        tx_bit_next   = tx_bit_reg;
        tx_shift_next = tx_shift_reg;
        latch_next    = latch_reg;
        tx_line_next  = tx_line_reg;
        pend_next     = pend_reg || reply_req;
        tx_done       = 1'b0;
        case (tx_state_reg)
            mio_pkg::MIO_IDLE: begin
                tx_cnt_next  = 16'h0000;
                tx_line_next = 1'b1;
                if (pend_reg || reply_req) begin
                    // Capture first, then send the captured copy, never the live inputs
                    latch_next    = status_word;
                    tx_shift_next = status_word;
                    tx_line_next  = 1'b0;
                    pend_next     = 1'b0;
                    tx_state_next = mio_pkg::MIO_START;
                end
            end
            mio_pkg::MIO_START: begin
                if (tx_cnt_reg == FULL_LAST) begin
                    tx_cnt_next   = 16'h0000;
                    tx_bit_next   = 3'h0;
                    tx_line_next  = tx_shift_reg[0];
                    tx_state_next = mio_pkg::MIO_DATA;
                end
            end
            mio_pkg::MIO_DATA: begin
                if (tx_cnt_reg == FULL_LAST) begin
                    tx_cnt_next   = 16'h0000;
                    tx_bit_next   = tx_bit_reg + 3'h1;
                    tx_shift_next = {1'b0, tx_shift_reg[7:1]};
                    tx_line_next  = tx_shift_reg[1];
                    if (tx_bit_reg == 3'h7) begin
                        tx_line_next  = 1'b1;
                        tx_state_next = mio_pkg::MIO_STOP;
                    end
                end
            end
            mio_pkg::MIO_STOP: begin
                if (tx_cnt_reg == FULL_LAST) begin
                    tx_cnt_next   = 16'h0000;
                    tx_done       = 1'b1;
                    tx_state_next = mio_pkg::MIO_IDLE;
                end
            end
            default: begin
                tx_line_next  = 1'b1;
                tx_state_next = mio_pkg::MIO_IDLE;
            end
        endcase
    end

    // Transmit registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_state_reg <= mio_pkg::MIO_IDLE;
            tx_cnt_reg   <= 16'h0000;
            tx_bit_reg   <= 3'h0;
            tx_shift_reg <= 8'hFF;
            latch_reg    <= 8'hFF;
            tx_line_reg  <= 1'b1;
            pend_reg     <= 1'b0;
        end else begin
            tx_state_reg <= tx_state_next;
            tx_cnt_reg   <= tx_cnt_next;
            tx_bit_reg   <= tx_bit_next;
            tx_shift_reg <= tx_shift_next;
            latch_reg    <= latch_next;
            tx_line_reg  <= tx_line_next;
            pend_reg     <= pend_next;
        end
    end

    // Register port: writes, read data one cycle later, read-to-clear interrupt status
    always_comb begin
        cmd_next   = cmd_reg;
        ctrl_next  = ctrl_reg;
        mask_next  = mask_reg;
        irqst_next = irqst_reg;
        rdata_next = 8'h00;
        if (reg_wr) begin
            case (reg_addr)
                `MIO_OFS_COMMAND:  cmd_next  = reg_wdata;
                `MIO_OFS_IRQ_MASK: mask_next = reg_wdata;
                `MIO_OFS_CTRL:     ctrl_next = {6'h00, reg_wdata[1:0]};
                default: begin
                end
            endcase
        end
        // A command off the link overrides a local write in the same cycle
        if (rx_valid) begin
            cmd_next = rx_data;
        end
        if (reg_rd) begin
            case (reg_addr)
                `MIO_OFS_COMMAND:   rdata_next = cmd_reg;
                `MIO_OFS_STATUS:    rdata_next = status_word;
                `MIO_OFS_IRQ_STAT: begin
                    rdata_next = irqst_reg;
                    irqst_next = 8'h00;
                end
                `MIO_OFS_IRQ_MASK:  rdata_next = mask_reg;
                `MIO_OFS_CTRL:      rdata_next = ctrl_reg;
                `MIO_OFS_LAST_SENT: rdata_next = latch_reg;
                default:            rdata_next = 8'h00;
            endcase
        end
        // Setting wins over the read clear so no event is lost
        irqst_next[`MIO_IRQ_CMD_RX]    = irqst_next[`MIO_IRQ_CMD_RX]    || rx_valid;
        irqst_next[`MIO_IRQ_STAT_TX]   = irqst_next[`MIO_IRQ_STAT_TX]   || tx_done;
        irqst_next[`MIO_IRQ_FRAME_ERR] = irqst_next[`MIO_IRQ_FRAME_ERR] || rx_ferr;
        irqst_next[`MIO_IRQ_ESTOP]     = irqst_next[`MIO_IRQ_ESTOP]     || estop_event;
        irq_next = |(irqst_next & mask_reg);
    end

    // Register file flip-flops; low-active drive bits reset high, i.e. off
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_reg        <= `MIO_CMD_RESET;
            ctrl_reg       <= `MIO_CTRL_RESET;
            mask_reg       <= `MIO_MASK_RESET;
            irqst_reg      <= `MIO_IRQ_RESET;
            rdata_reg      <= 8'h00;
            irq_reg        <= 1'b0;
            crash_prev_reg <= 1'b1;
        end else begin
            cmd_reg        <= cmd_next;
            ctrl_reg       <= ctrl_next;
            mask_reg       <= mask_next;
            irqst_reg      <= irqst_next;
            rdata_reg      <= rdata_next;
            irq_reg        <= irq_next;
            crash_prev_reg <= crash_prev_next;
        end
    end

    // Outputs straight from flip-flops, fixed bit assignment of the command word
    assign status_led_on        = cmd_reg[`MIO_CMD_LED];
    assign drive_passthru       = cmd_reg[`MIO_CMD_PASS];
    assign mist_triac_on        = cmd_reg[`MIO_CMD_MIST];
    assign flood_triac_on       = cmd_reg[`MIO_CMD_FLOOD];
    assign spindle_enable_n     = cmd_reg[`MIO_CMD_SPINDLE_N];
    assign index_solenoid_n     = cmd_reg[`MIO_CMD_INDEX_N];
    assign speed_inc_solenoid_n = cmd_reg[`MIO_CMD_SPD_INC_N];
    assign speed_dec_solenoid_n = cmd_reg[`MIO_CMD_SPD_DEC_N];
    assign link_tx              = tx_line_reg;
    assign reg_rdata            = rdata_reg;
    assign irq                  = irq_reg;

endmodule : mio_top

/* testbench/mio_top_asserts.sv */
// Checker of mio_top: register port, reset state, command outputs, reply framing.
// Assumes one clock domain; bound to every mio_top instance below.
module mio_top_asserts (
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       arst_n,
    // Link and machine outputs
    input wire logic       link_tx,
    input wire logic       status_led_on,
    input wire logic       drive_passthru,
    input wire logic       mist_triac_on,
    input wire logic       flood_triac_on,
    input wire logic       spindle_enable_n,
    input wire logic       index_solenoid_n,
    input wire logic       speed_inc_solenoid_n,
    input wire logic       speed_dec_solenoid_n,
    // Register port and interrupt
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic [7:0] out_word;
    // Output pins packed in command bit order
    assign out_word = {speed_dec_solenoid_n, speed_inc_solenoid_n, index_solenoid_n,
        spindle_enable_n, flood_triac_on, mist_triac_on, drive_passthru, status_led_on};
    a_cmd_readback: assert property (
        reg_rd && reg_addr == 4'h0 |=> reg_rdata == $past(out_word))
        else $error("command readback differs from outputs");
    a_reset_values: assert property (
        $rose(arst_n) |-> out_word == 8'hF0 && link_tx && !irq)
        else $error("outputs not at reset values");
    a_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    a_unmapped_zero: assert property (
        reg_rd && reg_addr > 4'h5 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_ctrl_readback: assert property (
        (reg_wr && reg_addr == 4'h4) ##2 (reg_rd && reg_addr == 4'h4)
        |=> reg_rdata == ($past(reg_wdata, 3) & 8'h03))
        else $error("control readback wrong");
    a_mask_readback: assert property (
        (reg_wr && reg_addr == 4'h3) ##2 (reg_rd && reg_addr == 4'h3)
        |=> reg_rdata == $past(reg_wdata, 3))
        else $error("mask readback wrong");
    a_irq_masked_off: assert property (
        (reg_wr && reg_addr == 4'h3 && reg_wdata == 8'h00) ##1 !reg_wr |-> ##1 !irq)
        else $error("interrupt high with mask cleared");
    a_start_bit_hold: assert property (
        $fell(link_tx) |-> !link_tx [*8])
        else $error("reply start bit too short");
    // Main scenarios reached
    c_cmd_write: cover property (reg_wr && reg_addr == 4'h0);
    c_irq_rise: cover property ($rose(irq));
    c_reply: cover property ($fell(link_tx));
endmodule : mio_top_asserts

bind mio_top mio_top_asserts u_mio_top_asserts (
    .core_clk(core_clk), .arst_n(arst_n), .link_tx(link_tx),
    .status_led_on(status_led_on), .drive_passthru(drive_passthru),
    .mist_triac_on(mist_triac_on), .flood_triac_on(flood_triac_on),
    .spindle_enable_n(spindle_enable_n), .index_solenoid_n(index_solenoid_n),
    .speed_inc_solenoid_n(speed_inc_solenoid_n), .speed_dec_solenoid_n(speed_dec_solenoid_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));

/* testbench/mio_host_model.sv */
// Host-side partner: sends command bytes and collects status replies, 8N1 LSB first.
// Assumes the bench calls send_cmd and watches reply_count and last_reply.
module mio_host_model #(
    parameter int BIT_CYCLES = 16
) (
    // Clock
    input wire logic core_clk,
    // Serial link
    input wire logic link_tx,
    output logic     link_rx
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] last_reply;
    int         reply_count;
    logic [9:0] frame;
    // Line idles high between frames
    initial begin
        link_rx = 1'b1;
        reply_count = 0;
        last_reply = 8'h00;
    end
    // One command frame; a low stop bit provokes a framing fault on purpose
    task automatic send_cmd(input logic [7:0] cmd, input logic stop_bit);
        frame = {stop_bit, cmd, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge core_clk);
            link_rx <= frame[i];
            repeat (BIT_CYCLES - 1) @(posedge core_clk);
        end
        @(posedge core_clk);
        link_rx <= 1'b1;
    endtask : send_cmd
    // Reply sampled mid-cell from the start edge; a bad stop drops the byte
    initial forever begin : rx_proc
        logic [7:0] b;
        @(negedge link_tx);
        repeat (BIT_CYCLES / 2) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(posedge core_clk);
            b[i] = link_tx;
        end
        repeat (BIT_CYCLES) @(posedge core_clk);
        if (link_tx === 1'b1) begin
            last_reply = b;
            reply_count++;
        end
    end
endmodule : mio_host_model

/* testbench/mio_top_bench.sv */
// Self-checking bench of mio_top: reset state, status word, link commands, interrupts.
// Assumes mio_host_model on the link and mio_top_asserts bound to the design.
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
    $display("unexpected at %0t: got %h want %h", $time, got, exp); end end

module mio_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BITS = 16;
    logic       core_clk = 1'b0;
    logic       arst_n = 1'b0;
    logic       link_rx;
    logic       link_tx;
    logic [9:0] mach = 10'h31F; // {estop, crash_n, rev, start, fault, out, in, z, y, x}
    logic [9:0] nm;
    logic [7:0] outs;
    logic [7:0] reg_rdata;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] cmd;
    logic [3:0] reg_addr = 4'h0;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic       irq;
    int         seed = 68;
    int         miscompares = 0;
    int         checks_done = 0;
    logic [11:0] rst_tab [6] = '{12'h0F0, 12'h200, 12'h300, 12'h403, 12'h5FF, 12'hF00};

    mio_top #(.BIT_CYCLES(BITS)) u_mio_top (
        .core_clk(core_clk), .arst_n(arst_n), .link_rx(link_rx), .link_tx(link_tx),
        .x_home_closed_n(mach[0]), .y_home_closed_n(mach[1]), .z_home_closed_n(mach[2]),
        .index_in_closed_n(mach[3]), .index_out_closed_n(mach[4]), .drive_fault(mach[5]),
        .spindle_start_on(mach[6]), .spindle_reverse_on(mach[7]),
        .system_crash_line_n(mach[8]), .estop_released(mach[9]),
        .status_led_on(outs[0]), .drive_passthru(outs[1]), .mist_triac_on(outs[2]),
        .flood_triac_on(outs[3]), .spindle_enable_n(outs[4]), .index_solenoid_n(outs[5]),
        .speed_inc_solenoid_n(outs[6]), .speed_dec_solenoid_n(outs[7]),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq));
    mio_host_model #(.BIT_CYCLES(BITS)) u_mio_host_model (
        .core_clk(core_clk), .link_tx(link_tx), .link_rx(link_rx));

    // 125 MHz core clock
    always #4 core_clk = ~core_clk;

    // Expected status word: every bit low-true
    function automatic logic [7:0] status_of(input logic [9:0] m);
        return {m[8] & m[9], ~(m[6] | m[7]), ~m[5], m[4:0]};
    endfunction : status_of

    // One-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // One-cycle read strobe, data taken in the following cycle only
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, exp)
    endtask : rd_chk

    // Command over the link, then wait a bounded time for the status reply
    task automatic link_cmd(input logic [7:0] c);
        int n;
        n = u_mio_host_model.reply_count;
        u_mio_host_model.send_cmd(c, 1'b1);
        for (int k = 0; k < 400 && u_mio_host_model.reply_count == n; k++) @(posedge core_clk);
        `CHK(u_mio_host_model.reply_count, n + 1)
    endtask : link_cmd

    task automatic summarize();
        $display("checks_done %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    // Hang guard, well past the expected run of a few thousand cycles
    initial begin : watchdog
        #200000;
        miscompares++;
        summarize();
    end

    initial begin : main
        repeat (3) @(posedge core_clk);
        #1 `CHK({outs, link_tx, irq}, {8'hF0, 1'b1, 1'b0})
        @(posedge core_clk);
        arst_n <= 1'b1;
        foreach (rst_tab[i]) rd_chk(rst_tab[i][11:8], rst_tab[i][7:0]);
        // Walk each machine input alone, then random words
        for (int i = 0; i < 16; i++) begin
            nm = (i < 10) ? (10'h31F ^ (10'h001 << i)) : 10'($random(seed));
            @(posedge core_clk);
            mach <= nm;
            rd_chk(4'h1, status_of(nm));
        end
        mach <= 10'h31F;
        // The crash walk above left one stop event pending
        rd_chk(4'h2, 8'h08);
        rd_chk(4'h2, 8'h00);
        // Link disabled: byte ignored, no reply
        wr(4'h4, 8'hFC);
        rd_chk(4'h4, 8'h00);
        u_mio_host_model.send_cmd(8'h00, 1'b1);
        repeat (200) @(posedge core_clk);
        #1 `CHK({outs, 8'(u_mio_host_model.reply_count)}, {8'hF0, 8'h00})
        // Receive on, replies off: command lands, host hears nothing
        wr(4'h4, 8'h01);
        u_mio_host_model.send_cmd(8'h3C, 1'b1);
        repeat (200) @(posedge core_clk);
        #1 `CHK({outs, 8'(u_mio_host_model.reply_count)}, {8'h3C, 8'h00})
        wr(4'h4, 8'h03);
        wr(4'h3, 8'h03);
        rd_chk(4'h3, 8'h03);
        // Commands with corner values, then random; reply carries latched status
        for (int i = 0; i < 6; i++) begin
            cmd = (i == 0) ? 8'h0F : (i == 1) ? 8'hF0 : (i == 2) ? 8'h00 : 8'($random(seed));
            nm = {2'b11, 8'($random(seed))};
            @(posedge core_clk);
            mach <= nm;
            link_cmd(cmd);
            repeat (BITS + 2) @(posedge core_clk);
            #1 `CHK(outs, cmd)
            `CHK(u_mio_host_model.last_reply, status_of(nm))
            `CHK(irq, 1'b1)
            rd_chk(4'h2, 8'h03);
            rd_chk(4'h5, status_of(nm));
            `CHK(irq, 1'b0)
        end
        // Masked events still land in status
        wr(4'h3, 8'h00);
        link_cmd(8'h55);
        repeat (BITS + 2) @(posedge core_clk);
        #1 `CHK(irq, 1'b0)
        rd_chk(4'h2, 8'h03);
        wr(4'h0, 8'hA5);
        #1 `CHK(outs, 8'hA5)
        // Bad stop bit: command dropped, framing event raised
        wr(4'h3, 8'h04);
        u_mio_host_model.send_cmd(8'h00, 1'b0);
        repeat (BITS) @(posedge core_clk);
        #1 `CHK({outs, irq}, {8'hA5, 1'b1})
        rd_chk(4'h2, 8'h04);
        // Crash line, then emergency stop, each reported as a stop event
        wr(4'h3, 8'h08);
        for (int j = 8; j < 10; j++) begin
            nm = 10'h31F ^ (10'h001 << j);
            @(posedge core_clk);
            mach <= nm;
            repeat (3) @(posedge core_clk);
            #1 `CHK(irq, 1'b1)
            rd_chk(4'h2, 8'h08);
            rd_chk(4'h1, status_of(nm));
            mach <= 10'h31F;
        end
        // Reset in mid-run restores the initial state
        wr(4'h0, 8'h0F);
        @(posedge core_clk);
        arst_n <= 1'b0;
        @(posedge core_clk);
        #1 `CHK({outs, irq}, {8'hF0, 1'b0})
        @(posedge core_clk);
        arst_n <= 1'b1;
        rd_chk(4'h3, 8'h00);
        summarize();
    end
endmodule : mio_top_bench
